/* File: design/sfdre_pkg.sv */
// package: opcodes, frame lengths and defaults for the dtr read engine
package sfdre_pkg;
   localparam logic [7:0] INFO_ROW_READ_CMD = 8'h68;
   localparam logic [7:0] SINGLE_LINE_DTR_READ_CMD = 8'h0d;
   localparam logic [7:0] DUAL_LINE_DTR_READ_CMD = 8'hbd;
   localparam logic [3:0] OPCODE_SKIP_NIBBLE = 4'ha;
   localparam int ADDR_BITS = 24;
   localparam logic [5:0] INFO_DUMMY_DEF = 6'h08;
   localparam logic [5:0] SINGLE_DUMMY_DEF = 6'h08;
   localparam logic [5:0] QUAD_DUMMY_DEF = 6'h06;
   localparam logic [5:0] DUAL_DUMMY_DEF = 6'h04;
   localparam logic [7:0] ROW_LAST_BYTE = 8'hff;
   // link clock divider: last count of a half period, equal to half of LINK_PERIOD_NS in system clocks
   localparam int SYS_PERIOD_NS = 5;
   localparam int LINK_PERIOD_NS = 130;
   localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   localparam logic [7:0] LINK_HALF_CNT = 8'(LINK_HALF_CYC);
   typedef enum logic [1:0] {
      SFDRE_INFO, SFDRE_SDTR, SFDRE_DDTR, SFDRE_QDTR
   } sfdre_kind_e;
   // bits per sampling edge in address and data phases
   function automatic logic [3:0] sfdreLanes(input sfdre_kind_e k);
      case (k)
         SFDRE_INFO: sfdreLanes = 4'h1;
         SFDRE_SDTR: sfdreLanes = 4'h1;
         SFDRE_DDTR: sfdreLanes = 4'h2;
         default: sfdreLanes = 4'h4;
      endcase
   endfunction
endpackage

/* File: design/sfdre_if.sv */
// interface: serial flash link pins between host and device
`timescale 1ns/10ps
`default_nettype none
interface sfdre_if;
   logic chipSelectN;
   logic serialClock;
   logic [3:0] hostIo;
   logic [3:0] hostIoOe;
   logic [3:0] devIo;
   logic [3:0] devIoOe;
   logic [3:0] io;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io[i] = devIoOe[i] ? devIo[i] : (hostIoOe[i] ? hostIo[i] : 1'b1);
      end
   end
   modport device (input chipSelectN, serialClock, io,
      output devIo, devIoOe);
   modport host (output chipSelectN, serialClock, hostIo, hostIoOe,
      input io);
endinterface
`default_nettype wire

/* File: design/sfdre_device.sv */
// device end: read command decoder and shift data path
// Function
// RULE1: info read: opcode, 24 address, dummies on rise
// RULE2: info read data shifts out on falling edge
// RULE3: info address increments, row end gives garbage
// RULE4: host reads each row separately, 256 bytes; sfdre_host sends any byteCount, across a row end too
// RULE5: chip select rise ends info read
// RULE6: info read ignored while write in progress
// RULE7: quad mode info read framed like quad read
// RULE8: single dtr: opcode, ddr address, 8 dummies
// RULE9: single dtr moves bits on both edges
// RULE10: single dtr address increments and wraps
// RULE11: chip select rise stops single dtr output
// RULE12: single dtr rejected while write in progress
// RULE13: quad dtr: two opcode clocks, 8 bits per clock
// RULE14: quad command dtr never enters skip mode
// RULE15: quad dtr rejected while write in progress
// RULE16: dual dtr: opcode, 4 bits per clock, 4 dummies
// RULE17: dual dtr two bits per edge
// RULE18: dual dtr address increments and wraps
// RULE19: mode nibble a enters opcode skip mode
// RULE20: host sets enough dummies, tristates low nibble
// RULE21: dual dtr rejected while write in progress; frames in opcode skip mode are not rejected
// RULE22: chip select rise readies new command
// RULE23: flag high during internal write, low after
// RULE24: chip select rise resets decoder, keeps skip
`timescale 1ns/10ps
`default_nettype none
module sfdre_device
   import sfdre_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   sfdre_if.device link,
   input wire logic quadCmdMode,
   input wire logic writeBusy,
   input wire logic [5:0] infoDummy,
   input wire logic [5:0] singleDummy,
   input wire logic [5:0] dualDummy,
   input wire logic [5:0] quadDummy,
   output logic [23:0] memAddr,
   input wire logic [7:0] memData,
   output logic write_in_progress_flag,
   output logic opcode_skip_read_mode
);
   typedef enum logic [2:0] {
      S_OPC, S_ADDR, S_DUMMY, S_DATA, S_IGNORE
   } sfdre_state_e;
   // ---------------------------------------------------------------
   // pin synchronisers, three stages
   // ---------------------------------------------------------------
   logic [2:0] csSync_q, sckSync_q;
   logic [3:0] ioS1_q, ioS2_q, ioS3_q;
   logic csN, sck, sckRise, sckFall, csRise;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         csSync_q <= 3'h7;
         sckSync_q <= 3'h0;
         ioS1_q <= 4'hf;
         ioS2_q <= 4'hf;
         ioS3_q <= 4'hf;
      end else begin
         csSync_q <= {csSync_q[1:0], link.chipSelectN};
         sckSync_q <= {sckSync_q[1:0], link.serialClock};
         ioS1_q <= link.io;
         ioS2_q <= ioS1_q;
         ioS3_q <= ioS2_q;
      end
   end
   logic csState_q, sckState_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         csState_q <= 1'b1;
         sckState_q <= 1'b0;
      end else begin
         if (csSync_q[1] == csSync_q[2]) csState_q <= csSync_q[2];
         if (sckSync_q[1] == sckSync_q[2]) sckState_q <= sckSync_q[2];
      end
   end
   assign csN = (csSync_q[1] == csSync_q[2]) ? csSync_q[2] : csState_q;
   assign sck = (sckSync_q[1] == sckSync_q[2]) ? sckSync_q[2] : sckState_q;
   assign sckRise = !csN && sck && !sckState_q;
   assign sckFall = !csN && !sck && sckState_q;
   assign csRise = csN && !csState_q;
   // ---------------------------------------------------------------
   // write in progress flag
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) write_in_progress_flag <= 1'b0;
      else write_in_progress_flag <= writeBusy; // [RULE23]
   end
   // ---------------------------------------------------------------
   // command decoder and phase sequencing
   // ---------------------------------------------------------------
   sfdre_state_e state_q;
   sfdre_kind_e kind_q;
   logic [7:0] opc_q;
   logic [5:0] cnt_q;
   logic [23:0] addr_q;
   logic [7:0] shift_q;
   logic [7:0] mode_q;
   logic [3:0] lanes, ioIn;
   logic ddr, edgeHit, riseOnly;
   logic [7:0] opcNext;
   assign lanes = sfdreLanes(kind_q);
   assign ddr = kind_q != SFDRE_INFO;
   assign ioIn = ioS3_q;
   assign edgeHit = sckRise || (ddr && sckFall); // [RULE9] [RULE17]
   // opcode bits and the first address chunk land on a rise
   assign riseOnly = state_q == S_OPC || (state_q == S_ADDR && cnt_q == 6'h00);
   assign opcNext = quadCmdMode ? {opc_q[3:0], ioIn} : {opc_q[6:0], ioIn[0]};
   function automatic logic [23:0] shiftIn(input logic [23:0] a,
      input logic [3:0] n, input logic [3:0] d);
      case (n)
         4'h1: shiftIn = {a[22:0], d[0]};
         4'h2: shiftIn = {a[21:0], d[1:0]};
         default: shiftIn = {a[19:0], d};
      endcase
   endfunction
   logic [5:0] opcLast, addrLast, dumLast, bitLast;
   assign opcLast = quadCmdMode ? 6'd1 : 6'd7; // [RULE7] [RULE13]
   assign addrLast = 6'(ADDR_BITS / 32'(lanes)) - 6'd1;
   assign bitLast = 6'(8 / 32'(lanes)) - 6'd1;
   always_comb begin
      unique case (kind_q)
         SFDRE_INFO: dumLast = infoDummy - 6'd1; // [RULE1]
         SFDRE_SDTR: dumLast = (singleDummy << 1) - 6'd1; // [RULE8]
         SFDRE_DDTR: dumLast = (dualDummy << 1) - 6'd1; // [RULE16]
         SFDRE_QDTR: dumLast = (quadDummy << 1) - 6'd1; // [RULE13]
      endcase
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= S_OPC;
         kind_q <= SFDRE_INFO;
         opc_q <= 8'h00;
         cnt_q <= 6'h00;
         addr_q <= 24'h000000;
         mode_q <= 8'h00;
         opcode_skip_read_mode <= 1'b0;
      end else if (csRise) begin
         state_q <= S_OPC; // [RULE5] [RULE22] [RULE24]
         cnt_q <= 6'h00;
         if (opcode_skip_read_mode) kind_q <= SFDRE_DDTR;
      end else if (state_q == S_OPC && !csN && csState_q
            && opcode_skip_read_mode) begin
         state_q <= S_ADDR; // skip mode starts at the address
         kind_q <= SFDRE_DDTR;
         cnt_q <= 6'h00;
      end else if (riseOnly ? sckRise : edgeHit) begin
         unique case (state_q)
            S_OPC: begin
               opc_q <= opcNext;
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == opcLast) begin
                  cnt_q <= 6'h00;
                  state_q <= S_ADDR;
                  if (write_in_progress_flag)
                     state_q <= S_IGNORE; // [RULE6] [RULE12] [RULE15] [RULE21]
                  else if (opcNext == INFO_ROW_READ_CMD)
                     kind_q <= quadCmdMode ? SFDRE_QDTR : SFDRE_INFO;
                  else if (opcNext == SINGLE_LINE_DTR_READ_CMD)
                     kind_q <= quadCmdMode ? SFDRE_QDTR : SFDRE_SDTR;
                  else if (opcNext == DUAL_LINE_DTR_READ_CMD && !quadCmdMode)
                     kind_q <= SFDRE_DDTR;
                  else state_q <= S_IGNORE;
               end
            end
            S_ADDR: begin
               addr_q <= shiftIn(addr_q, lanes, ioIn);
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == addrLast) begin
                  cnt_q <= 6'h00;
                  state_q <= S_DUMMY;
               end
            end
            S_DUMMY: begin
               if (cnt_q < 6'd2)
                  mode_q <= (lanes == 4'h2) ? {mode_q[5:0], ioIn[1:0]}
                     : {mode_q[3:0], ioIn};
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == dumLast) begin
                  cnt_q <= 6'h00;
                  state_q <= S_DATA;
                  if (kind_q == SFDRE_DDTR)
                     opcode_skip_read_mode <=
                        mode_q[3:0] == OPCODE_SKIP_NIBBLE; // [RULE19]
                  else if (kind_q == SFDRE_QDTR)
                     opcode_skip_read_mode <= 1'b0; // [RULE14]
               end
            end
            S_DATA: begin
               cnt_q <= cnt_q + 6'd1;
               if (cnt_q == 6'h00) begin
                  // step early so memData holds the next byte at reload
                  if (kind_q == SFDRE_INFO)
                     addr_q[7:0] <= addr_q[7:0] + 8'd1; // [RULE3]
                  else
                     addr_q <= addr_q + 24'd1; // [RULE10] [RULE18]
               end
               if (cnt_q == bitLast) cnt_q <= 6'h00;
            end
            default: ;
         endcase
      end
   end
   assign memAddr = addr_q;
   // ---------------------------------------------------------------
   // output shifter, launched on falling edge or either edge
   // ---------------------------------------------------------------
   logic outLaunch, outOn_q, rowEnd_q;
   logic [3:0] ioOut_q;
   assign outLaunch = state_q == S_DATA && (sckFall || (ddr && sckRise)); // [RULE2]
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         shift_q <= 8'h00;
         ioOut_q <= 4'h0;
         outOn_q <= 1'b0;
         rowEnd_q <= 1'b0;
      end else if (state_q != S_DATA || csN) begin
         outOn_q <= 1'b0; // [RULE11]
         shift_q <= memData;
         rowEnd_q <= 1'b0;
      end else if (outLaunch) begin
         outOn_q <= 1'b1;
         if (kind_q == SFDRE_INFO && cnt_q == 6'h00
               && addr_q[7:0] == ROW_LAST_BYTE)
            rowEnd_q <= 1'b1; // [RULE3]
         unique case (lanes)
            4'h1: begin
               ioOut_q <= {3'h0, shift_q[7]};
               shift_q <= {shift_q[6:0], 1'b0};
            end
            4'h2: begin
               ioOut_q <= {2'h0, shift_q[7:6]};
               shift_q <= {shift_q[5:0], 2'h0};
            end
            default: begin
               ioOut_q <= shift_q[7:4];
               shift_q <= {shift_q[3:0], 4'h0};
            end
         endcase
         if (cnt_q == bitLast) shift_q <= rowEnd_q ? 8'hff : memData;
      end
   end
   always_comb begin
      link.devIo = 4'h0;
      link.devIoOe = 4'h0;
      unique case (lanes)
         4'h1: begin
            link.devIo = {2'h0, ioOut_q[0], 1'b0};
            link.devIoOe = {2'h0, outOn_q, 1'b0};
         end
         4'h2: begin
            link.devIo = {2'h0, ioOut_q[1:0]};
            link.devIoOe = {2'h0, {2{outOn_q}}};
         end
         default: begin
            link.devIo = ioOut_q;
            link.devIoOe = {4{outOn_q}};
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: design/sfdre_host.sv */
// host end: issues one read frame and collects returned bytes
`timescale 1ns/10ps
`default_nettype none
module sfdre_host
   import sfdre_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   sfdre_if.host link,
   input wire logic startRead,
   input wire sfdre_kind_e readKind,
   input wire logic quadCmdMode,
   input wire logic skipOpcode,
   input wire logic [7:0] modeByte,
   input wire logic [23:0] readAddr,
   input wire logic [5:0] dummyClocks,
   input wire logic [9:0] byteCount,
   output logic busy,
   output logic [7:0] rxByte,
   output logic rxValid
);
   typedef enum logic [2:0] {
      H_IDLE, H_OPC, H_ADDR, H_DUMMY, H_DATA, H_END
   } sfdre_hstate_e;
   sfdre_hstate_e state_q;
   sfdre_kind_e kind_q;
   logic [7:0] div_q, opc_q, rx_q;
   logic sck_q;
   logic [5:0] cnt_q;
   logic [23:0] addr_q;
   logic [9:0] left_q;
   logic [3:0] lanes, lastBit;
   logic [5:0] addrLast, dumLast;
   logic tick, ddr;
   assign lanes = sfdreLanes(kind_q);
   assign ddr = kind_q != SFDRE_INFO;
   assign tick = div_q == LINK_HALF_CNT;
   assign addrLast = 6'(ADDR_BITS / 32'(lanes)) - 6'd1;
   assign dumLast = ddr ? (dummyClocks << 1) - 6'd1 : dummyClocks - 6'd1;
   assign lastBit = 4'(8 / 32'(lanes)) - 4'd1;
   // -----------------------------------------------------------------
   // frame sequencer; opcode and sdr bits change on fall, ddr phases change on both edges
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= H_IDLE;
         kind_q <= SFDRE_INFO;
         div_q <= 8'h00;
         sck_q <= 1'b0;
         cnt_q <= 6'h00;
         opc_q <= 8'h00;
         addr_q <= 24'h000000;
         left_q <= 10'h000;
         rx_q <= 8'h00;
         rxByte <= 8'h00;
         rxValid <= 1'b0;
      end else begin
         rxValid <= 1'b0;
         div_q <= (tick || state_q == H_IDLE) ? 8'h00 : div_q + 8'd1;
         unique case (state_q)
            H_IDLE: if (startRead) begin
               kind_q <= quadCmdMode ? SFDRE_QDTR : readKind;
               addr_q <= readAddr;
               left_q <= byteCount;
               cnt_q <= skipOpcode ? 6'h3f : 6'h00;
               case (readKind)
                  SFDRE_INFO: opc_q <= INFO_ROW_READ_CMD;
                  SFDRE_DDTR: opc_q <= DUAL_LINE_DTR_READ_CMD;
                  default: opc_q <= SINGLE_LINE_DTR_READ_CMD;
               endcase
               state_q <= skipOpcode ? H_ADDR : H_OPC;
            end
            H_END: if (tick) begin
               sck_q <= 1'b0; // park the clock low as the frame closes
               state_q <= H_IDLE;
            end
            default: if (tick) begin
               sck_q <= !sck_q;
               if (sck_q || (ddr && state_q != H_OPC)) begin
                  cnt_q <= cnt_q + 6'd1;
                  if (state_q == H_OPC && cnt_q ==
                        (quadCmdMode ? 6'd1 : 6'd7)) begin
                     cnt_q <= ddr ? 6'h3f : 6'h00; // ddr address opens on rise
                     state_q <= H_ADDR;
                  end else if (state_q == H_ADDR && cnt_q == addrLast) begin
                     cnt_q <= 6'h00;
                     state_q <= H_DUMMY;
                  end else if (state_q == H_DUMMY && cnt_q == dumLast) begin
                     cnt_q <= 6'h00;
                     state_q <= H_DATA;
                  end else if (state_q == H_DATA) begin
                     rx_q <= (lanes == 4'h4) ? {rx_q[3:0], link.io} :
                        (lanes == 4'h2) ? {rx_q[5:0], link.io[1:0]} :
                        {rx_q[6:0], link.io[1]};
                     if (cnt_q[3:0] == lastBit) begin
                        cnt_q <= 6'h00;
                        rxValid <= 1'b1;
                        rxByte <= (lanes == 4'h4) ? {rx_q[3:0], link.io} :
                           (lanes == 4'h2) ? {rx_q[5:0], link.io[1:0]} :
                           {rx_q[6:0], link.io[1]};
                        left_q <= left_q - 10'd1;
                        if (left_q == 10'd1) state_q <= H_END;
                     end
                  end
               end
            end
         endcase
      end
   end
   // -----------------------------------------------------------------
   // pin drive
   // -----------------------------------------------------------------
   logic [3:0] hOut, hOe;
   always_comb begin
      hOut = 4'h0;
      hOe = 4'h0;
      if (state_q == H_OPC) begin
         hOe = quadCmdMode ? 4'hf : 4'h1;
         hOut = quadCmdMode ? (cnt_q[0] ? opc_q[3:0] : opc_q[7:4])
            : {3'h0, opc_q[3'(7 - cnt_q[2:0])]};
      end else if (state_q == H_ADDR) begin
         hOe = (lanes == 4'h4) ? 4'hf : (lanes == 4'h2) ? 4'h3 : 4'h1;
         hOut = 4'((addr_q >> (ADDR_BITS - 32'(lanes) * (32'(cnt_q) + 1)))
            & 24'(hOe));
      end else if (state_q == H_DUMMY && cnt_q == 6'h00 && ddr) begin
         hOe = (lanes == 4'h2) ? 4'h3 : 4'hf;
         hOut = (lanes == 4'h2) ? {2'h0, modeByte[7:6]} : modeByte[7:4];
      end else if (state_q == H_DUMMY && cnt_q == 6'h01 && ddr) begin
         hOe = (lanes == 4'h2) ? 4'h3 : 4'h0;
         hOut = {2'h0, modeByte[5:4]};
      end
   end
   assign link.chipSelectN = state_q == H_IDLE;
   assign link.serialClock = sck_q;
   assign link.hostIo = hOut;
   assign link.hostIoOe = hOe;
   assign busy = state_q != H_IDLE;
endmodule
`default_nettype wire

/* File: tb/sfdre_checker.sv */
// checker: link pin timing between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module sfdre_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic chipSelectN,
   input wire logic serialClock,
   input wire logic [3:0] hostIoOe,
   input wire logic [3:0] devIoOe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------
   // sequences
   // ---------------------------------------------
   sequence csIdle;
      chipSelectN [*8];
   endsequence
   sequence devQuiet;
      (devIoOe == 4'h0) [*8];
   endsequence
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   chk_idle_silent: assert property (csIdle |-> devIoOe == 4'h0)
      else $error("device drives with chip select idle");
   chk_cs_stop: assert property (
      $rose(chipSelectN) |-> ##[0:8] devIoOe == 4'h0)
      else $error("device output not released after frame end");
   chk_start_quiet: assert property ($fell(chipSelectN) |-> devQuiet)
      else $error("device drives during opcode");
   chk_no_clash: assert property ((devIoOe & hostIoOe) == 4'h0)
      else $error("host and device drive one line");
   chk_lane_set: assert property (
      devIoOe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("device drives an odd lane set");
   chk_mode_zero: assert property ($fell(chipSelectN) |-> !serialClock)
      else $error("frame starts with link clock high");
   chk_clk_high: assert property (
      $rose(serialClock) |-> serialClock [*8])
      else $error("link clock high phase too short");
   chk_clk_parked: assert property (csIdle |-> !serialClock)
      else $error("link clock runs outside a frame");
endmodule
`default_nettype wire

/* File: tb/serial_flash_dtr_read_engine_bench.sv */
// testbench: host and device ends joined over the link
`timescale 1ns/10ps
`default_nettype none
module serial_flash_dtr_read_engine_bench;
   import sfdre_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic startRead = 1'b0;
   sfdre_kind_e readKind = SFDRE_INFO;
   logic quadCmdMode = 1'b0;
   logic skipOpcode = 1'b0;
   logic writeBusy = 1'b0;
   logic [7:0] modeByte = 8'h00;
   logic [23:0] readAddr = 24'h000000;
   logic [5:0] dummyClocks = 6'h08;
   logic [9:0] byteCount = 10'h001;
   logic busy, rxValid, wipFlag, skipFlag;
   logic [7:0] rxByte;
   logic [23:0] memAddr;
   logic [7:0] memData;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   function automatic logic [7:0] pat(input logic [23:0] a);
      pat = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
   endfunction
   assign memData = pat(memAddr);
   always #2.5 clock = ~clock;
   // ---------------------------------------------
   // instances
   // ---------------------------------------------
   sfdre_if sfdre_if_i ();
   sfdre_device sfdre_device_i (.clock(clock), .reset_n(reset_n),
      .link(sfdre_if_i), .quadCmdMode(quadCmdMode), .writeBusy(writeBusy),
      .infoDummy(INFO_DUMMY_DEF), .singleDummy(SINGLE_DUMMY_DEF),
      .dualDummy(DUAL_DUMMY_DEF), .quadDummy(QUAD_DUMMY_DEF),
      .memAddr(memAddr), .memData(memData),
      .write_in_progress_flag(wipFlag), .opcode_skip_read_mode(skipFlag));
   sfdre_host sfdre_host_i (.clock(clock), .reset_n(reset_n),
      .link(sfdre_if_i), .startRead(startRead), .readKind(readKind),
      .quadCmdMode(quadCmdMode), .skipOpcode(skipOpcode),
      .modeByte(modeByte), .readAddr(readAddr), .dummyClocks(dummyClocks),
      .byteCount(byteCount), .busy(busy), .rxByte(rxByte),
      .rxValid(rxValid));
   sfdre_checker sfdre_checker_i (.clock(clock), .reset_n(reset_n),
      .chipSelectN(sfdre_if_i.chipSelectN),
      .serialClock(sfdre_if_i.serialClock),
      .hostIoOe(sfdre_if_i.hostIoOe), .devIoOe(sfdre_if_i.devIoOe));
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one frame; refused frames read back the pulled-up lines
   task automatic run_read(input sfdre_kind_e k, input logic q,
      input logic s, input logic [7:0] m, input logic [23:0] a,
      input logic [5:0] d, input logic [9:0] n, input logic refused);
      logic [23:0] ea;
      int got;
      int guard;
      logic past;
      ea = a;
      got = 0;
      guard = 0;
      past = 1'b0;
      readKind = k;
      quadCmdMode = q;
      skipOpcode = s;
      modeByte = m;
      readAddr = a;
      dummyClocks = d;
      byteCount = n;
      startRead = 1'b1;
      @(negedge clock);
      startRead = 1'b0;
      while (busy !== 1'b0 && guard < 20000) begin
         if (rxValid === 1'b1) begin
            check({24'h0, rxByte}, {24'h0, (refused || past) ? 8'hff : pat(ea)});
            ea = ea + 24'h1;
            if (k == SFDRE_INFO && !q && ea[7:0] == 8'h00) past = 1'b1;
            got++;
         end
         @(negedge clock);
         guard++;
      end
      check(got, {22'h0, n});
      repeat (16) @(negedge clock);
   endtask
   task automatic flags(input logic w, input logic sk);
      check({30'h0, wipFlag, skipFlag}, {30'h0, w, sk});
   endtask
   // ---------------------------------------------
   // timeout
   // ---------------------------------------------
   always @(posedge clock) begin
      cycles++;
      if (cycles == 80000) begin
         miscompares++;
         end_sim();
      end
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (3) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      flags(1'b0, 1'b0);
      run_read(SFDRE_INFO, 1'b0, 1'b0, 8'h00, 24'h0010fc, 6'h08, 10'h004, 1'b0);
      run_read(SFDRE_INFO, 1'b0, 1'b0, 8'h00, 24'h003000, 6'h08, 10'h002, 1'b0);
      run_read(SFDRE_INFO, 1'b0, 1'b0, 8'h00, 24'h0020fe, 6'h08, 10'h003, 1'b0);
      run_read(SFDRE_SDTR, 1'b0, 1'b0, 8'h00, 24'hfffffe, 6'h08, 10'h004, 1'b0);
      run_read(SFDRE_SDTR, 1'b0, 1'b0, 8'h00, 24'h123456, 6'h08, 10'h001, 1'b0);
      run_read(SFDRE_DDTR, 1'b0, 1'b0, 8'h00, 24'hfffffe, 6'h04, 10'h003, 1'b0);
      run_read(SFDRE_SDTR, 1'b1, 1'b0, 8'ha5, 24'hfffffe, 6'h06, 10'h003, 1'b0);
      flags(1'b0, 1'b0);
      run_read(SFDRE_INFO, 1'b1, 1'b0, 8'h00, 24'h002010, 6'h06, 10'h002, 1'b0);
      run_read(SFDRE_DDTR, 1'b0, 1'b0, 8'ha5, 24'h0000ff, 6'h04, 10'h002, 1'b0);
      flags(1'b0, 1'b1);
      run_read(SFDRE_DDTR, 1'b0, 1'b1, 8'ha0, 24'h000100, 6'h04, 10'h002, 1'b0);
      flags(1'b0, 1'b1);
      run_read(SFDRE_DDTR, 1'b0, 1'b1, 8'h50, 24'h00abcd, 6'h04, 10'h002, 1'b0);
      flags(1'b0, 1'b0);
      writeBusy = 1'b1;
      repeat (8) @(negedge clock);
      flags(1'b1, 1'b0);
      run_read(SFDRE_INFO, 1'b0, 1'b0, 8'h00, 24'h001000, 6'h08, 10'h002, 1'b1);
      run_read(SFDRE_SDTR, 1'b0, 1'b0, 8'h00, 24'h000010, 6'h08, 10'h002, 1'b1);
      run_read(SFDRE_DDTR, 1'b0, 1'b0, 8'ha5, 24'h000020, 6'h04, 10'h002, 1'b1);
      flags(1'b1, 1'b0);
      run_read(SFDRE_SDTR, 1'b1, 1'b0, 8'h00, 24'h000030, 6'h06, 10'h002, 1'b1);
      writeBusy = 1'b0;
      repeat (8) @(negedge clock);
      flags(1'b0, 1'b0);
      run_read(SFDRE_DDTR, 1'b0, 1'b0, 8'h00, 24'h7f00fe, 6'h04, 10'h003, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
